// file: core/flash_ops_regs.svh
// Constants for the serial flash page/buffer command block.
// Assumes inclusion by bare name from core/.
`ifndef FLASH_OPS_REGS_SVH
`define FLASH_OPS_REGS_SVH
`define OP_SECREG_READ      8'h77
`define OP_XFER_BUF1        8'h53
`define OP_XFER_BUF2        8'h55
`define OP_COMP_BUF1        8'h60
`define OP_COMP_BUF2        8'h61
`define OP_REWRITE_BUF1     8'h58
`define OP_REWRITE_BUF2     8'h59
`define OP_STATUS_READ      8'hD7
`define SECREG_BYTES        128
`define SECREG_USER_LAST    63
`define ADDR_BYTES          3
`define STAT_READY_BIT      7
`define STAT_COMP_BIT       6
`define STAT_PAGE_BIT       0
`define PAGE_SIZE_264       1'b0
`define PAGE_SIZE_256       1'b1
`define IDX264_LSB          9
`define IDX256_LSB          8
`define SYS_CLK_MHZ         250
`define XFER_TIME_NS        200000
`define COMP_TIME_NS        200000
`define EP_TIME_NS          25000000
`define REWRITE_MAX         50000
`endif

// file: core/flash_ops_pkg.sv
// Types shared by both ends of the serial flash command link.
// Assumes nothing beyond a SystemVerilog compiler.
package flash_ops_pkg;
	typedef enum logic [2:0] {
		OP_NONE,
		OP_XFER,
		OP_COMP,
		OP_REWRITE,
		OP_RMW
	} array_op_e;
	typedef logic [10:0] page_t;
endpackage

// file: core/flash_link_if.sv
// Serial link between a flash host and the flash command block.
// Assumes a single sys_clk; the serial clock is a sampled level.
`timescale 1ns/1ps
interface flash_link_if;
	logic csHigh_b;
	logic sck;
	logic si;
	logic so;
	logic soOe;
	modport dev  (input csHigh_b, input sck, input si, output so, output soOe);
	modport host (output csHigh_b, output sck, output si, input so, input soOe);
endinterface

// file: core/flash_ops_dev.sv
// Device end: decodes serial commands, streams the security register,
// and runs timed transfer, compare and rewrite operations.
// Assumes sck is a slow level sampled on sys_clk, mode 0.
//
// What this block does
// - 77h plus three dummies streams security bytes
// - Past last byte, output data reads as zeros
// - Chip select high ends read, tristates output
// - 128 bytes: user 0-63, factory 64-127
// - 53h/55h transfer page to buffer 1/2
// - 264 format: 4 dummy, 11 index, 9 dummy
// - 256 format: 5 dummy, 11 index, 8 dummy
// - Page-size bit 0=264, 1=256 selects format
// - Host keeps select low while clocking command
// - Transfer starts on select rise; busy during time
// - 60h/61h compare page with buffer 1/2
// - Compare on select rise; busy compare time
// - Compare outcome written to status bit 6
// - Compare bit 0 match, 1 differ
// - Ready bit 7: 0 busy, 1 idle
// - 58h/59h rewrite page via buffer 1/2
// - Rewrite copies and reprograms; busy erase-program time
// - Host refreshes sector pages each 50000 operations; flash_ops_host keeps no count, REWRITE_MAX is unused
// - Data after rewrite address means read-modify-write
`timescale 1ns/1ps
`include "flash_ops_regs.svh"
module flash_ops_dev #(
	parameter int XFER_CYC = (`XFER_TIME_NS * `SYS_CLK_MHZ + 999) / 1000,
	parameter int COMP_CYC = (`COMP_TIME_NS * `SYS_CLK_MHZ + 999) / 1000,
	// Divide first: the full product overflows a 32-bit int
	parameter int EP_CYC   = (`EP_TIME_NS / 1000) * `SYS_CLK_MHZ
) (
	// Clock and reset
	input  wire logic          sys_clk,
	input  wire logic          rst_b,
	// Serial link
	flash_link_if.dev          link,
	// Configuration and array side
	input  wire logic          pageSize256,
	input  wire logic [1023:0] secRegImage,
	input  wire logic          pageMismatch,
	output logic               opStart,
	output flash_ops_pkg::array_op_e opKind,
	output logic               opBuf2,
	output flash_ops_pkg::page_t opPage,
	output logic               busy,
	output logic [7:0]         statusByte
);
	import flash_ops_pkg::*;

	logic        sckPrev;
	logic        csPrev;
	logic [5:0]  bitCnt;
	logic [7:0]  shiftIn;
	logic [7:0]  opcode;
	logic [23:0] addr;
	logic [2:0]  byteNum;
	logic        dataSeen;
	logic [7:0]  outByte;
	logic [7:0]  secIdx;
	logic [2:0]  outBit;
	logic        soReg;
	logic [31:0] timer;
	logic        compResult;
	array_op_e   runKind;
	array_op_e   pendOp;

	wire sckRise = link.sck & ~sckPrev & ~link.csHigh_b;
	wire sckFall = ~link.sck & sckPrev & ~link.csHigh_b;
	wire csRise  = link.csHigh_b & ~csPrev;
	wire byteDone = sckRise && (bitCnt[2:0] == 3'h7);
	wire [7:0] nextByte = {shiftIn[6:0], link.si};
	// Status repeats byte one; security data starts after the dummies
	wire streamOn = (opcode == `OP_SECREG_READ) && (byteNum > 3'(`ADDR_BYTES))
		|| (opcode == `OP_STATUS_READ) && (byteNum != 3'h0);

	function automatic page_t pick_page(input logic [23:0] a, input logic sz);
		return (sz == `PAGE_SIZE_256) ? a[`IDX256_LSB +: 11] : a[`IDX264_LSB +: 11];
	endfunction

	function automatic array_op_e decode_op(input logic [7:0] op, input logic data);
		unique case (op)
			`OP_XFER_BUF1, `OP_XFER_BUF2:       decode_op = OP_XFER;
			`OP_COMP_BUF1, `OP_COMP_BUF2:       decode_op = OP_COMP;
			`OP_REWRITE_BUF1, `OP_REWRITE_BUF2: decode_op = data ? OP_RMW : OP_REWRITE;
			default:                            decode_op = OP_NONE;
		endcase
	endfunction

	// Buffer 2 codes; the transfer pair breaks the low-bit pattern
	function automatic logic is_buf2(input logic [7:0] op);
		unique case (op)
			`OP_XFER_BUF2, `OP_COMP_BUF2, `OP_REWRITE_BUF2: is_buf2 = 1'b1;
			default:                                        is_buf2 = 1'b0;
		endcase
	endfunction

	assign pendOp = decode_op(opcode, dataSeen);

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			// Idle pin levels, so reset leaves no false edge
			sckPrev <= 1'b0;
			csPrev  <= 1'b1;
		end else begin
			sckPrev <= link.sck;
			csPrev  <= link.csHigh_b;
		end
	end

	// Input shifting and byte counting while selected
	always_ff @(posedge sys_clk) begin
		if (!rst_b || link.csHigh_b) begin
			bitCnt   <= '0;
			shiftIn  <= '0;
			byteNum  <= '0;
			dataSeen <= 1'b0;
			if (!rst_b) begin
				opcode <= '0;
				addr   <= '0;
			end
		end else if (sckRise) begin
			bitCnt  <= bitCnt + 6'h01;
			shiftIn <= nextByte;
			if (byteDone) begin
				if (byteNum == 3'h0)
					opcode <= nextByte;
				else if (byteNum <= 3'(`ADDR_BYTES))
					addr <= {addr[15:0], nextByte};
				else
					dataSeen <= 1'b1;
				if (byteNum != 3'h7)
					byteNum <= byteNum + 3'h1;
			end
		end
	end

	// Output stream: security register or status
	always_ff @(posedge sys_clk) begin
		if (!rst_b || link.csHigh_b) begin
			secIdx  <= '0;
			outBit  <= '0;
			soReg   <= 1'b0;
		end else if (sckFall && streamOn) begin
			outBit <= outBit + 3'h1;
			soReg  <= outByte[3'h7 - outBit];
			if (outBit == 3'h7 && secIdx != 8'hFF)
				secIdx <= secIdx + 8'h01;
		end
	end

	always_comb begin
		if (opcode == `OP_STATUS_READ)
			outByte = statusByte;
		else if (secIdx < 8'(`SECREG_BYTES))
			outByte = secRegImage[secIdx[6:0]*8 +: 8];
		// Past the last byte the host gets zeros
		else
			outByte = 8'h00;
	end

	assign link.so   = soReg;
	assign link.soOe = ~link.csHigh_b && streamOn;

	// Array operation launch and timing
	// Commands landing while busy are dropped, not queued
	always_ff @(posedge sys_clk) begin
		opStart <= 1'b0;
		if (!rst_b) begin
			busy       <= 1'b0;
			timer      <= '0;
			runKind    <= OP_NONE;
			compResult <= 1'b0;
			opKind     <= OP_NONE;
			opBuf2     <= 1'b0;
			opPage     <= '0;
		end else if (busy) begin
			// Runs down to one so busy spans exactly the loaded count
			if (timer <= 32'h1) begin
				busy <= 1'b0;
				if (runKind == OP_COMP)
					compResult <= pageMismatch;
			end else begin
				timer <= timer - 32'h1;
			end
		end else if (csRise && byteNum > 3'(`ADDR_BYTES)
			&& pendOp != OP_NONE) begin
			busy    <= 1'b1;
			opStart <= 1'b1;
			runKind <= pendOp;
			opKind  <= pendOp;
			opBuf2  <= is_buf2(opcode);
			opPage  <= pick_page(addr, pageSize256);
			unique case (pendOp)
				OP_XFER: timer <= 32'(XFER_CYC);
				OP_COMP: timer <= 32'(COMP_CYC);
				default: timer <= 32'(EP_CYC);
			endcase
		end
	end

	always_comb begin
		statusByte = 8'h00;
		statusByte[`STAT_READY_BIT] = ~busy;
		statusByte[`STAT_COMP_BIT]  = compResult;
		statusByte[`STAT_PAGE_BIT]  = pageSize256;
	end
endmodule

// file: core/flash_ops_host.sv
// Host end: shifts commands with page addresses out over the link.
// Assumes the device end samples sck on sys_clk.
`timescale 1ns/1ps
`include "flash_ops_regs.svh"
module flash_ops_host #(
	parameter int HALF_CYC = 4
) (
	// Clock and reset
	input  wire logic         sys_clk,
	input  wire logic         rst_b,
	// Serial link
	flash_link_if.host        link,
	// User command port
	input  wire logic         cmdValid,
	output logic              cmdReady,
	input  wire logic [7:0]   cmdOpcode,
	input  wire flash_ops_pkg::page_t cmdPage,
	input  wire logic         pageSize256,
	input  wire logic [7:0]   cmdReadBytes,
	output logic [7:0]        rdData,
	output logic              rdValid
);
	import flash_ops_pkg::*;

	typedef enum logic [1:0] {IDLE, SHIFT, DONE} host_state_e;
	host_state_e state;
	logic [31:0] txWord;
	logic [7:0]  bitsLeft;
	logic [7:0]  rdLeft;
	logic [7:0]  rdShift;
	logic [2:0]  rdBit;
	logic [7:0]  halfCnt;

	wire halfTick = (halfCnt == 8'(HALF_CYC - 1));
	wire [23:0] addrBytes = (pageSize256 == `PAGE_SIZE_256)
		? 24'({cmdPage, 8'h00}) : 24'({cmdPage, 9'h000});

	assign cmdReady = (state == IDLE);

	always_ff @(posedge sys_clk) begin
		if (!rst_b || state == IDLE)
			halfCnt <= '0;
		else
			halfCnt <= halfTick ? 8'h00 : halfCnt + 8'h01;
	end

	always_ff @(posedge sys_clk) begin
		rdValid <= 1'b0;
		if (!rst_b) begin
			state       <= IDLE;
			link.csHigh_b <= 1'b1;
			link.sck    <= 1'b0;
			link.si     <= 1'b0;
			txWord      <= '0;
			bitsLeft    <= '0;
			rdLeft      <= '0;
			rdShift     <= '0;
			rdBit       <= '0;
			rdData      <= '0;
		end else begin
			unique case (state)
				IDLE: if (cmdValid) begin
					state         <= SHIFT;
					link.csHigh_b <= 1'b0;
					txWord        <= {cmdOpcode, addrBytes};
					link.si       <= cmdOpcode[7];
					bitsLeft      <= 8'd32;
					rdLeft        <= cmdReadBytes;
					rdBit         <= '0;
				end
				SHIFT: if (halfTick) begin
					if (!link.sck) begin
						link.sck <= 1'b1;
						if (bitsLeft == 8'h00) begin
							rdShift <= {rdShift[6:0], link.so};
							rdBit   <= rdBit + 3'h1;
							if (rdBit == 3'h7) begin
								rdData  <= {rdShift[6:0], link.so};
								rdValid <= 1'b1;
								rdLeft  <= rdLeft - 8'h01;
							end
						end else begin
							bitsLeft <= bitsLeft - 8'h01;
							txWord   <= {txWord[30:0], 1'b0};
						end
					end else begin
						link.sck <= 1'b0;
						link.si  <= txWord[31];
						if (bitsLeft == 8'h00 && rdLeft == 8'h00)
							state <= DONE;
					end
				end
				DONE: begin
					link.csHigh_b <= 1'b1;
					state         <= IDLE;
				end
				default: state <= IDLE;
			endcase
		end
	end
endmodule

// file: bench/flash_link_properties.sv
// Checker on the serial link between host and device ends.
// Assumes one sys_clk domain and the host's HALF_CYC of 4.
`timescale 1ns/1ps
`include "flash_ops_regs.svh"
module flash_link_properties (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// Link signals
	input wire logic csHigh_b,
	input wire logic sck,
	input wire logic si,
	input wire logic so,
	input wire logic soOe
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	logic [7:0] rises;
	logic [7:0] opByte;

	// First byte of the frame tells a status stream from a security one
	always_ff @(posedge sys_clk) begin
		if (!rst_b || csHigh_b)
			opByte <= 8'h00;
		else if ($rose(sck) && rises < 8'h08)
			opByte <= {opByte[6:0], si};
	end

	// Saturates so long reads cannot wrap
	always_ff @(posedge sys_clk) begin
		if (!rst_b || csHigh_b)
			rises <= 8'h00;
		else if ($rose(sck) && rises != 8'hFF)
			rises <= rises + 8'h01;
	end

	oe_off_cs_a: assert property (csHigh_b |-> !soOe)
		else $error("so driven while deselected");
	oe_late_a: assert property ($rose(soOe)
		|-> rises == ((opByte == `OP_STATUS_READ) ? 8'h08 : 8'h20))
		else $error("data out before command bits");
	oe_end_a: assert property ($fell(soOe) |-> csHigh_b)
		else $error("so released inside frame");
	sck_frame_a: assert property ($changed(sck) |-> !csHigh_b)
		else $error("sck moved while deselected");
	sck_idle_a: assert property ($fell(csHigh_b) |-> !sck)
		else $error("frame opened with sck high");
	si_hold_a: assert property (sck && $past(sck) |-> $stable(si))
		else $error("si moved while sck high");
	sck_high_len_a: assert property ($rose(sck) |-> sck [*4] ##1 !sck)
		else $error("sck high phase wrong length");
	frame_len_a: assert property ($rose(csHigh_b) |-> rises >= 8'h20)
		else $error("frame shorter than opcode and address");
	cover property ($rose(soOe));
	cover property ($rose(csHigh_b) && rises == 8'h20);
	cover property (rises == 8'hC8);
	cover property ($rose(soOe) && opByte == `OP_STATUS_READ);
endmodule

// file: bench/serial_flash_page_buffer_ops_tb.sv
// Bench joining host and device ends over the serial link.
// Assumes the core/ files compile first.
`timescale 1ns/1ps
module serial_flash_page_buffer_ops_tb;
	import flash_ops_pkg::*;
	logic          sys_clk, rst_b, cmdValid, cmdReady, pageSize256, pageMismatch;
	logic          opStart, opBuf2, busy, rdValid;
	logic [7:0]    cmdOpcode, cmdReadBytes, rdData, statusByte;
	logic [7:0]    rd [0:255];
	logic [31:0]   frame;
	logic [1023:0] img;
	page_t         cmdPage, opPage;
	array_op_e     opKind;
	int            n_fail, n_tests, starts, busyCyc, idx;

	flash_link_if link();
	flash_ops_dev #(.XFER_CYC(20), .COMP_CYC(24), .EP_CYC(400)) i_flash_ops_dev (.sys_clk,
		.rst_b, .link, .pageSize256, .secRegImage(img), .pageMismatch, .opStart, .opKind,
		.opBuf2, .opPage, .busy, .statusByte);
	flash_ops_host i_flash_ops_host (.sys_clk, .rst_b, .link, .cmdValid, .cmdReady,
		.cmdOpcode, .cmdPage, .pageSize256, .cmdReadBytes, .rdData, .rdValid);
	flash_link_properties i_flash_link_properties (.sys_clk, .rst_b,
		.csHigh_b(link.csHigh_b), .sck(link.sck), .si(link.si), .so(link.so),
		.soOe(link.soOe));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %0h exp %0h", $time, got, exp);
		end
	endtask

	task automatic wrap_up();
		$display("tests %0d fails %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Host ready again, and optionally device idle
	task automatic settle(input bit idle);
		int i;
		int j;
		repeat (4) @(posedge sys_clk);
		for (i = 0; i < 9000 && cmdReady !== 1'b1; i++)
			@(posedge sys_clk);
		// Gap lets a launch from the closing chip select show as busy
		repeat (3) @(posedge sys_clk);
		for (j = 0; idle && j < 9000 && busy !== 1'b0; j++)
			@(posedge sys_clk);
		if (i == 9000 || j == 9000) begin
			n_fail++;
			wrap_up();
		end
		#1;
	endtask

	task automatic cmd(input logic [7:0] op, input page_t pg, input logic ps,
			input logic [7:0] nrd);
		@(posedge sys_clk);
		cmdOpcode <= op;
		cmdPage <= pg;
		cmdReadBytes <= nrd;
		pageSize256 <= ps;
		pageMismatch <= op[0];
		cmdValid <= 1'b1;
		@(posedge sys_clk);
		cmdValid <= 1'b0;
	endtask

	task automatic arr(input logic [7:0] op, input page_t pg, input logic ps,
			input logic b2, input array_op_e k, input int cyc);
		int n0;
		n0 = starts;
		cmd(op, pg, ps, 8'h00);
		settle(1);
		chk(starts, n0 + 1);
		chk(opKind, k);
		chk(opBuf2, b2);
		chk(opPage, pg);
		chk(frame, {op, ps ? {5'h00, pg, 8'h00} : {4'h0, pg, 9'h000}});
		chk(busyCyc, cyc);
		chk(statusByte[7], 1);
		chk(statusByte[0], ps);
		if (k == OP_COMP)
			chk(statusByte[6], op[0]);
	endtask

	task automatic t_secreg();
		idx = 0;
		cmd(8'h77, 11'h7FF, 1'b0, 8'h81);
		settle(0);
		chk(idx, 129);
		for (int i = 0; i < 128; i++)
			chk(rd[i], img[8*i +: 8]);
		chk(rd[128], 0);
		chk(link.soOe, 0);
		$display("security read done");
	endtask

	task automatic t_ops();
		logic [7:0] ops [6] = '{8'h53, 8'h55, 8'h60, 8'h61, 8'h58, 8'h59};
		array_op_e ks [6] = '{OP_XFER, OP_XFER, OP_COMP, OP_COMP, OP_REWRITE, OP_REWRITE};
		page_t pg [6] = '{11'h7FF, 11'h001, 11'h400, 11'h2AA, 11'h555, 11'h000};
		int cy [3] = '{20, 24, 400};
		for (int i = 0; i < 6; i++)
			arr(ops[i], pg[i], 1'(i[1] ^ i[0]), i[0], ks[i], cy[i/2]);
		$display("array ops done");
	endtask

	task automatic t_refuse();
		int n0;
		n0 = starts;
		cmd(8'h59, 11'h123, 1'b0, 8'h00);
		settle(0);
		chk(busy, 1);
		cmd(8'h53, 11'h321, 1'b0, 8'h00);
		settle(1);
		chk(starts, n0 + 1);
		chk(opPage, 11'h123);
		$display("busy refusal done");
	endtask

	task automatic t_rmw();
		int n0;
		n0 = starts;
		cmd(8'h58, 11'h0F0, 1'b1, 8'h01);
		settle(1);
		chk(starts, n0 + 1);
		chk(opKind, OP_RMW);
		$display("modify write done");
	endtask

	// Status stays readable while a rewrite runs
	task automatic t_status();
		int n0;
		n0 = starts;
		cmd(8'h58, 11'h00F, 1'b1, 8'h00);
		settle(0);
		cmd(8'hD7, 11'h000, 1'b1, 8'h01);
		settle(0);
		chk(rd[idx - 1], 8'h41);
		chk(starts, n0 + 1);
		settle(1);
		cmd(8'hD7, 11'h000, 1'b1, 8'h01);
		settle(0);
		chk(rd[idx - 1], 8'hC1);
		$display("status read done");
	endtask

	always @(posedge sys_clk) begin
		if ($rose(link.sck))
			frame <= {frame[30:0], link.si};
		if (opStart === 1'b1)
			starts <= starts + 1;
		// Start edge already carries busy, so it counts as one
		busyCyc <= (opStart === 1'b1) ? 1 : busyCyc + int'(busy === 1'b1);
		if (rdValid === 1'b1) begin
			rd[idx] <= rdData;
			idx <= idx + 1;
		end
		if (busy === 1'b1)
			chk(statusByte[7], 0);
	end

	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	initial begin
		{rst_b, cmdValid, cmdOpcode, cmdPage, cmdReadBytes} = '0;
		{pageSize256, pageMismatch, frame} = '0;
		{n_fail, n_tests, starts, busyCyc, idx} = '0;
		for (int i = 0; i < 128; i++)
			img[8*i +: 8] = 8'(i) ^ 8'hC3;
		repeat (2) @(posedge sys_clk);
		rst_b <= 1'b1;
		settle(1);
		t_secreg();
		t_ops();
		t_refuse();
		t_rmw();
		t_status();
		wrap_up();
	end
endmodule
